/* File: core/mds_pkg.sv */
// Constants, codes and carriers for the modulation data source
package mds_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_RATE   = 8'h04;
    localparam logic [7:0] REG_ROLL   = 8'h08;
    localparam logic [7:0] REG_DELAY  = 8'h0c;
    localparam logic [7:0] REG_INHIB  = 8'h10;
    localparam logic [7:0] REG_DLEN   = 8'h14;
    localparam logic [7:0] REG_MADDR  = 8'h18;
    localparam logic [7:0] REG_MDATA  = 8'h1c;
    localparam logic [7:0] REG_CADDR  = 8'h20;
    localparam logic [7:0] REG_CENTRY = 8'h24;
    localparam logic [7:0] REG_CCOUNT = 8'h28;
    localparam logic [7:0] REG_CMD    = 8'h2c;
    localparam logic [7:0] REG_STATUS = 8'h30;
    localparam logic [7:0] REG_FREE   = 8'h34;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int F_SRC  = 0;
    localparam int F_CLST = 2;
    localparam int F_ENV  = 3;
    localparam int F_TRIG = 5;
    localparam int F_PAT  = 7;
    localparam int F_GMSK = 8;
    localparam int F_RCOS = 9;
    localparam int F_PRBS = 10;
    localparam int F_MEXT = 13;
    localparam int F_LIST = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Field codes
    localparam logic [1:0] SRC_LIST = 2'h0;
    localparam logic [1:0] SRC_PRBS = 2'h1;
    localparam logic [1:0] SRC_PAT  = 2'h2;
    localparam logic [1:0] ENV_ANA  = 2'h0;
    localparam logic [1:0] ENV_EXTD = 2'h1;
    localparam logic [1:0] ENV_INT  = 2'h2;
    localparam logic [1:0] TRG_AUTO = 2'h0;
    localparam logic [1:0] TRG_ONCE = 2'h1;
    localparam logic [1:0] TRG_RTRG = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h0;
    localparam logic [1:0] LVL_ATT  = 2'h1;
    localparam logic [1:0] LVL_MAX  = 2'h2;
    // ------------------------------------------------------------
    // Limits, sizes, seeds
    // ------------------------------------------------------------
    localparam logic [15:0] GMSK_MAX_KSPS = 16'h1d4c; // 7500 ksymb/s
    localparam logic [15:0] ENV_MAX_KSPS  = 16'h09c4; // 2500 ksymb/s
    localparam logic [7:0]  ROLL_MIN      = 8'h0f;    // 0.15 in hundredths
    localparam logic [7:0]  ROLL_MAX      = 8'h46;    // 0.70 in hundredths
    localparam logic [6:0]  MAX_LISTS     = 7'h7d;    // 125
    localparam logic [26:0] MEM_BASE      = 27'h100_0000; // 16 Mbit
    localparam logic [26:0] MEM_EXT32     = 27'h200_0000;
    localparam logic [26:0] MEM_EXT64     = 27'h400_0000;
    localparam int          DATA_WORDS    = 64;
    localparam logic [11:0] DATA_BITS     = 12'h800;
    localparam int          CENTRIES      = 16;
    localparam logic [22:0] PRBS_SEED     = 23'h7f_ffff;
    localparam logic [2:0]  PRBS_LAST     = 3'h5;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic envelope_on_bit;
        logic level_reduce_bit;
        logic carrier_only_bit;
        logic frequency_step_bit;
        logic marker_out_two;
        logic marker_out_one;
    } mds_ctrl_s;
    typedef struct packed {
        mds_ctrl_s   bits;
        logic [23:0] idx;
    } mds_entry_s;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mds_req_s;
    typedef enum logic [1:0] {PLAY_IDLE, PLAY_DELAY, PLAY_RUN} mds_play_e;
endpackage

/* File: core/mds_source.sv */
// Modulation data source: list playback, PRBS, pattern, triggers, checks
`timescale 1ns/1ps
module mds_source (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire mds_pkg::mds_req_s  req,
    output logic [31:0]             rdata,
    input  wire logic               bit_tick,
    input  wire logic               sym_tick,
    input  wire logic               external_trigger_input,
    input  wire logic               ext_envelope_on,
    input  wire logic               ext_level_reduce,
    input  wire logic               ext_carrier_only,
    output logic                    mod_bit,
    output logic                    mod_valid,
    output mds_pkg::mds_ctrl_s      rear_parallel_port,
    output logic [1:0]              level_attenuate,
    output logic                    carrier_only,
    output logic                    frequency_step,
    output logic                    trigger_echo_output,
    output logic                    param_clash
);
    import mds_pkg::*;
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] trg_q, trg_d;
    logic [2:0] xs1_q, xs2_q;
    always_comb begin
        trg_d = {trg_q[1:0], external_trigger_input};
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trg_q <= 3'h0;
            xs1_q <= 3'h0;
            xs2_q <= 3'h0;
        end else if (ce) begin
            trg_q <= trg_d;
            xs1_q <= {ext_envelope_on, ext_level_reduce, ext_carrier_only};
            xs2_q <= xs1_q;
        end
    end
    // ------------------------------------------------------------
    // Configuration registers and list memories
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] rate_q, rate_d, dly_q, dly_d, inh_q, inh_d;
    logic [7:0]  roll_q, roll_d;
    logic [11:0] dlen_q, dlen_d;
    logic [5:0]  maddr_q, maddr_d;
    logic [3:0]  caddr_q, caddr_d;
    logic [4:0]  ccnt_q, ccnt_d;
    logic [31:0] mem_q [DATA_WORDS];
    logic [31:0] mem_d [DATA_WORDS];
    mds_entry_s  ent_q [CENTRIES];
    mds_entry_s  ent_d [CENTRIES];
    logic        man_trig;
    function automatic logic hit(input mds_req_s r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction
    always_comb begin
        ctrl_d  = ctrl_q;
        rate_d  = rate_q;
        roll_d  = roll_q;
        dly_d   = dly_q;
        inh_d   = inh_q;
        dlen_d  = dlen_q;
        maddr_d = maddr_q;
        caddr_d = caddr_q;
        ccnt_d  = ccnt_q;
        mem_d   = mem_q;
        ent_d   = ent_q;
        if (hit(req, REG_CTRL))  ctrl_d = req.wdata;
        if (hit(req, REG_RATE))  rate_d = req.wdata[15:0];
        if (hit(req, REG_ROLL))  roll_d = req.wdata[7:0];
        if (hit(req, REG_DELAY)) dly_d = req.wdata[15:0];
        if (hit(req, REG_INHIB)) inh_d = req.wdata[15:0];
        // Bitwise list: length in bits, clipped to what is fitted
        if (hit(req, REG_DLEN)) begin
            dlen_d = (req.wdata[11:0] > DATA_BITS) ? DATA_BITS : req.wdata[11:0];
        end
        if (hit(req, REG_MADDR)) maddr_d = req.wdata[5:0];
        if (hit(req, REG_MDATA)) begin
            mem_d[maddr_q] = req.wdata;
            maddr_d        = maddr_q + 6'h1;
        end
        if (hit(req, REG_CADDR)) caddr_d = req.wdata[3:0];
        if (hit(req, REG_CENTRY)) begin
            ent_d[caddr_q] = req.wdata[29:0];
            caddr_d        = caddr_q + 4'h1;
        end
        if (hit(req, REG_CCOUNT)) begin
            ccnt_d = (req.wdata[4:0] > 5'h10) ? 5'h10 : req.wdata[4:0];
        end
    end
    assign man_trig = hit(req, REG_CMD) && req.wdata[0];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= CTRL_RST;
            rate_q  <= 16'h0;
            roll_q  <= ROLL_MIN;
            dly_q   <= 16'h0;
            inh_q   <= 16'h0;
            dlen_q  <= 12'h0;
            maddr_q <= 6'h0;
            caddr_q <= 4'h0;
            ccnt_q  <= 5'h0;
            for (int i = 0; i < DATA_WORDS; i++) mem_q[i] <= 32'h0;
            for (int i = 0; i < CENTRIES; i++) ent_q[i] <= 30'h0;
        end else if (ce) begin
            ctrl_q  <= ctrl_d;
            rate_q  <= rate_d;
            roll_q  <= roll_d;
            dly_q   <= dly_d;
            inh_q   <= inh_d;
            dlen_q  <= dlen_d;
            maddr_q <= maddr_d;
            caddr_q <= caddr_d;
            ccnt_q  <= ccnt_d;
            mem_q   <= mem_d;
            ent_q   <= ent_d;
        end
    end
    // ------------------------------------------------------------
    // Setting checks
    // ------------------------------------------------------------
    logic [1:0] src, env_src, trig_mode, mext;
    logic [2:0] prbs_sel;
    logic [6:0] list_sel;
    logic       clist_on, list_ctrl, clash_now;
    assign src       = ctrl_q[F_SRC+:2];
    assign clist_on  = ctrl_q[F_CLST];
    assign env_src   = ctrl_q[F_ENV+:2];
    assign trig_mode = ctrl_q[F_TRIG+:2];
    assign prbs_sel  = ctrl_q[F_PRBS+:3];
    assign mext      = ctrl_q[F_MEXT+:2];
    assign list_sel  = ctrl_q[F_LIST+:7];
    // Control list only runs beside data list playback
    assign list_ctrl = clist_on && (src == SRC_LIST);
    // The setting stays stored; only the flag tells software it is unusable
    assign clash_now = (ctrl_q[F_GMSK] && (rate_q > GMSK_MAX_KSPS))
                    || (ctrl_q[F_RCOS] && ((roll_q < ROLL_MIN) || (roll_q > ROLL_MAX)))
                    || ((env_src != ENV_ANA) && (rate_q > ENV_MAX_KSPS))
                    || ((src == SRC_LIST) && (env_src == ENV_EXTD))
                    || (clist_on && (src != SRC_LIST))
                    || (list_sel >= MAX_LISTS)
                    || (src == 2'h3) || (env_src == 2'h3) || (trig_mode == 2'h3)
                    || (prbs_sel > PRBS_LAST) || (mext == 2'h3);
    // ------------------------------------------------------------
    // Playback, PRBS, triggers
    // ------------------------------------------------------------
    function automatic logic [22:0] prbs_next(input logic [22:0] s, input logic [2:0] sel);
        logic [22:0] n;
        n = {1'b0, s[22:1]};
        unique case (sel)
            3'h0:    n[8]  = s[4] ^ s[0];
            3'h1:    n[14] = s[1] ^ s[0];
            3'h2:    n[15] = s[5] ^ s[3] ^ s[2] ^ s[0];
            3'h3:    n[19] = s[3] ^ s[0];
            3'h4:    n[20] = s[2] ^ s[0];
            default: n[22] = s[5] ^ s[0];
        endcase
        prbs_next = n;
    endfunction
    mds_play_e   st_q, st_d;
    logic [10:0] dptr_q, dptr_d;
    logic [23:0] sidx_q, sidx_d;
    logic [3:0]  cptr_q, cptr_d;
    mds_ctrl_s   cbits_q, cbits_d;
    logic [22:0] prbs_q, prbs_d;
    logic [2:0]  psel_q;
    logic [15:0] dcnt_q, dcnt_d, icnt_q, icnt_d;
    logic        mbit_q, mbit_d, echo_q, echo_d, hop_q, hop_d;
    logic        ext_edge, ext_ok, man_ok, trig_ev, open_ok, src_bit;
    logic [23:0] clen;
    assign ext_edge = trg_q[1] && !trg_q[2];
    assign open_ok  = (trig_mode == TRG_RTRG) || (st_q == PLAY_IDLE);
    assign ext_ok   = ext_edge && (icnt_q == 16'h0) && (trig_mode != TRG_AUTO) && open_ok;
    assign man_ok   = man_trig && (trig_mode != TRG_AUTO) && open_ok;
    assign trig_ev  = ext_ok || man_ok;
    assign clen     = (ccnt_q == 5'h0) ? 24'h0 : ent_q[ccnt_q[3:0] - 4'h1].idx;
    always_comb begin
        unique case (src)
            SRC_LIST: src_bit = (dlen_q != 12'h0) && mem_q[dptr_q[10:5]][5'h1f - dptr_q[4:0]];
            SRC_PRBS: src_bit = prbs_q[0];
            default:  src_bit = ctrl_q[F_PAT];
        endcase
    end
    always_comb begin
        st_d    = st_q;
        dptr_d  = dptr_q;
        sidx_d  = sidx_q;
        cptr_d  = cptr_q;
        cbits_d = cbits_q;
        prbs_d  = prbs_q;
        dcnt_d  = dcnt_q;
        icnt_d  = icnt_q;
        mbit_d  = mbit_q;
        hop_d   = 1'b0;
        echo_d  = trig_ev;
        if (trig_mode == TRG_AUTO && st_q != PLAY_RUN) st_d = PLAY_RUN;
        if (trig_ev) begin
            icnt_d = inh_q;
            dptr_d = 11'h0;
            sidx_d = 24'h1;
            cptr_d = 4'h0;
            prbs_d = PRBS_SEED;
            st_d   = (ext_ok && dly_q != 16'h0) ? PLAY_DELAY : PLAY_RUN;
            dcnt_d = dly_q;
        end else begin
            if (sym_tick && icnt_q != 16'h0) icnt_d = icnt_q - 16'h1;
            if (st_q == PLAY_DELAY && sym_tick) begin
                dcnt_d = dcnt_q - 16'h1;
                if (dcnt_q == 16'h1) st_d = PLAY_RUN;
            end
            if (st_q == PLAY_RUN && bit_tick) begin
                mbit_d = src_bit;
                prbs_d = prbs_next(prbs_q, prbs_sel);
                if ({1'b0, dptr_q} + 12'h1 >= dlen_q) begin
                    dptr_d = 11'h0;
                    if (trig_mode == TRG_ONCE && src == SRC_LIST) st_d = PLAY_IDLE;
                end else begin
                    dptr_d = dptr_q + 11'h1;
                end
            end
            if (st_q == PLAY_RUN && sym_tick && list_ctrl && ccnt_q != 5'h0) begin
                if (sidx_q == ent_q[cptr_q].idx) begin
                    cbits_d = ent_q[cptr_q].bits;
                    cptr_d  = cptr_q + 4'h1;
                    hop_d   = ent_q[cptr_q].bits.frequency_step_bit
                           && !cbits_q.frequency_step_bit;
                end
                if (sidx_q >= clen) begin
                    sidx_d = 24'h1;
                    cptr_d = 4'h0;
                end else begin
                    sidx_d = sidx_q + 24'h1;
                end
            end
        end
        // Reseed on a new length and on any lock-up
        if (prbs_sel != psel_q || prbs_d == 23'h0) prbs_d = PRBS_SEED;
        if (st_d != PLAY_RUN) mbit_d = 1'b0;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q    <= PLAY_IDLE;
            dptr_q  <= 11'h0;
            sidx_q  <= 24'h1;
            cptr_q  <= 4'h0;
            cbits_q <= 6'h0;
            prbs_q  <= PRBS_SEED;
            psel_q  <= 3'h0;
            dcnt_q  <= 16'h0;
            icnt_q  <= 16'h0;
            mbit_q  <= 1'b0;
            echo_q  <= 1'b0;
            hop_q   <= 1'b0;
        end else if (ce) begin
            st_q    <= st_d;
            dptr_q  <= dptr_d;
            sidx_q  <= sidx_d;
            cptr_q  <= cptr_d;
            cbits_q <= cbits_d;
            prbs_q  <= prbs_d;
            psel_q  <= prbs_sel;
            dcnt_q  <= dcnt_d;
            icnt_q  <= icnt_d;
            mbit_q  <= mbit_d;
            echo_q  <= echo_d;
            hop_q   <= hop_d;
        end
    end
    // ------------------------------------------------------------
    // Output control bits, envelope decode, read port
    // ------------------------------------------------------------
    mds_ctrl_s   par_q, par_d;
    logic [1:0]  lvl_q, lvl_d;
    logic        clash_q;
    logic [31:0] rd_q, rd_d;
    logic [26:0] cap;
    logic        gate, lred;
    always_comb begin
        par_d = list_ctrl ? cbits_q : {xs2_q, 3'h0};
        // Gate and reduce steer the envelope from the list bits in internal list mode and from the pins in external mode
        unique case (env_src)
            ENV_INT:  {gate, lred} = list_ctrl ? {cbits_q[5], cbits_q[4]} : 2'h2;
            ENV_EXTD: {gate, lred} = xs2_q[2:1];
            default:  {gate, lred} = 2'h2;
        endcase
        lvl_d = !gate ? LVL_MAX : (lred ? LVL_ATT : LVL_FULL);
        cap = MEM_BASE + ((mext == 2'h1) ? MEM_EXT32 : 27'h0)
                       + ((mext == 2'h2) ? MEM_EXT64 : 27'h0);
        rd_d = 32'h0;
        if (req.rd) begin
            unique case (req.addr)
                REG_CTRL:   rd_d = ctrl_q;
                REG_RATE:   rd_d = {16'h0, rate_q};
                REG_ROLL:   rd_d = {24'h0, roll_q};
                REG_DELAY:  rd_d = {16'h0, dly_q};
                REG_INHIB:  rd_d = {16'h0, inh_q};
                REG_DLEN:   rd_d = {20'h0, dlen_q};
                REG_MADDR:  rd_d = {26'h0, maddr_q};
                REG_CADDR:  rd_d = {28'h0, caddr_q};
                REG_CCOUNT: rd_d = {27'h0, ccnt_q};
                REG_STATUS: rd_d = {clen, 4'h0, st_q, list_ctrl, clash_q};
                REG_FREE:   rd_d = {5'h0, cap - {15'h0, dlen_q}};
                default:    rd_d = 32'h0;
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            par_q   <= 6'h0;
            lvl_q   <= LVL_MAX;
            clash_q <= 1'b0;
            rd_q    <= 32'h0;
        end else if (ce) begin
            par_q   <= par_d;
            lvl_q   <= lvl_d;
            clash_q <= clash_now;
            rd_q    <= rd_d;
        end
    end
    assign rdata               = rd_q;
    assign mod_bit             = mbit_q;
    assign mod_valid           = (st_q == PLAY_RUN) && !par_q.carrier_only_bit;
    assign rear_parallel_port  = par_q;
    assign level_attenuate     = lvl_q;
    assign carrier_only        = par_q.carrier_only_bit;
    assign frequency_step      = hop_q;
    assign trigger_echo_output = echo_q;
    assign param_clash         = clash_q;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_GMSK: assert property (ce && ctrl_q[F_GMSK] && rate_q > GMSK_MAX_KSPS |=> param_clash)
        else $error("GMSK over rate not flagged");
    AST_ROLL: assert property (ce && ctrl_q[F_RCOS] && roll_q > ROLL_MAX |=> param_clash)
        else $error("Roll-off over limit not flagged");
    AST_ENV: assert property (ce && env_src == ENV_INT && rate_q > ENV_MAX_KSPS |=> param_clash)
        else $error("Envelope over rate not flagged");
    AST_CLEAR: assert property (ce && !clash_now |=> !param_clash)
        else $error("Clash flag not cleared");
    AST_EXTENV: assert property (ce && src == SRC_LIST && env_src == ENV_EXTD |=> param_clash)
        else $error("External envelope with data list not flagged");
    AST_CLSRC: assert property (ce && src != SRC_LIST |=> rear_parallel_port[2:0] == 3'h0)
        else $error("List control bits with foreign source");
    AST_ECHO: assert property (ce && trig_ev |=> trigger_echo_output ##1 !trigger_echo_output || $past(trig_ev))
        else $error("Trigger echo missing");
    AST_RESTART: assert property (ce && trig_ev |=> dptr_q == 11'h0 && sidx_q == 24'h1)
        else $error("Trigger did not restart playback");
    AST_INHIB: assert property (ce && icnt_q != 16'h0 && ext_edge && !man_trig |=> !trigger_echo_output)
        else $error("Trigger accepted during inhibit");
    AST_DELAY: assert property (ce && ext_ok && dly_q != 16'h0 |=> st_q == PLAY_DELAY && !mod_valid)
        else $error("Delayed start ran early");
    AST_DECODE: assert property (ce && !gate |=> level_attenuate == LVL_MAX)
        else $error("Gate low not at maximum reduction");
    AST_CW: assert property (carrier_only |-> !mod_valid)
        else $error("Modulation not suspended");
    AST_NZ: assert property (prbs_q != 23'h0)
        else $error("PRBS register locked at zero");
    AST_AUTO: assert property (ce && trig_mode == TRG_AUTO |=> st_q == PLAY_RUN)
        else $error("Auto mode not running");
    COV_ECHO:  cover property (trigger_echo_output);
    COV_DELAY: cover property (st_q == PLAY_DELAY ##1 st_q == PLAY_RUN);
    COV_CLASH: cover property (param_clash ##1 !param_clash);
    COV_WRAP:  cover property (ce && st_q == PLAY_RUN && bit_tick && dptr_d == 11'h0);
endmodule

/* File: tb/mds_coder_model.sv */
// Coder-side model that captures the played modulation bits
`timescale 1ns/1ps
module mds_coder_model (
    input  wire logic       core_clk,
    input  wire logic       bit_tick,
    input  wire logic       mod_bit,
    input  wire logic       mod_valid,
    input  wire logic       trigger_echo_output,
    output logic [7:0]      cap,
    output logic [3:0]      n
);
    logic tick_q;
    // Bit is taken one edge after the tick that loaded it; stops at eight
    always @(posedge core_clk) begin
        tick_q <= bit_tick;
        if (trigger_echo_output) begin
            n <= 4'h0;
        end else if (tick_q && mod_valid && n != 4'h8) begin
            cap <= {cap[6:0], mod_bit};
            n   <= n + 4'h1;
        end
    end
endmodule

/* File: tb/mds_source_tb.sv */
// Self-checking bench for the modulation data source
`timescale 1ns/1ps
module mds_source_tb;
    import mds_pkg::*;
    logic        core_clk, rst, ext_trig, bit_tick, sym_tick, mod_bit, mod_valid, echo, clash;
    logic        cw, fstep;
    logic [2:0]  env_in;
    logic [1:0]  lvl, tk;
    logic [7:0]  cap;
    logic [3:0]  n;
    logic [31:0] rdata, rv;
    mds_req_s    req;
    mds_ctrl_s   rp;
    int          bad_count, total_checks, cyc;
    mds_source dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .req(req), .rdata(rdata),
        .bit_tick(bit_tick), .sym_tick(sym_tick), .external_trigger_input(ext_trig),
        .ext_envelope_on(env_in[2]), .ext_level_reduce(env_in[1]),
        .ext_carrier_only(env_in[0]), .mod_bit(mod_bit), .mod_valid(mod_valid),
        .rear_parallel_port(rp), .level_attenuate(lvl), .carrier_only(cw),
        .frequency_step(fstep), .trigger_echo_output(echo), .param_clash(clash));
    mds_coder_model coder (.core_clk(core_clk), .bit_tick(bit_tick), .mod_bit(mod_bit),
        .mod_valid(mod_valid), .trigger_echo_output(echo), .cap(cap), .n(n));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Bit strobe every second cycle, symbol strobe every fourth
    always @(posedge core_clk) begin
        tk       <= tk + 2'h1;
        bit_tick <= tk[0];
        sym_tick <= (tk == 2'h3);
        cyc      <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            summarize;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 rv = rdata;
    endtask
    // Apply one setting and judge the clash flag on pin and status
    task automatic row(input logic [31:0] c, r, f, input logic e);
        wr(REG_RATE, r);
        wr(REG_ROLL, f);
        wr(REG_CTRL, c);
        rd(REG_STATUS);
        chk({31'h0, clash}, {31'h0, e});
        chk({31'h0, rv[0]}, {31'h0, e});
    endtask
    task automatic t_env;
        wr(REG_CTRL, 32'h9);
        for (int v = 0; v < 4; v++) begin
            @(posedge core_clk);
            env_in <= {v[1], v[0], 1'b0};
            repeat (6) @(posedge core_clk);
            chk({26'h0, rp}, {26'h0, v[1], v[0], 4'h0});
            chk({30'h0, lvl}, v[1] ? {31'h0, v[0]} : 32'h2);
        end
    endtask
    // Three-bit list 110 in retrigger mode; capture must start at the first bit
    task automatic t_play;
        wr(REG_DLEN, 32'h3);
        wr(REG_MADDR, 32'h0);
        wr(REG_MDATA, 32'hc000_0000);
        wr(REG_CTRL, 32'h44);
        wr(REG_CMD, 32'h1);
        #1 chk({31'h0, echo}, 32'h1);
        repeat (40) @(posedge core_clk);
        chk({24'h0, cap}, 32'hdb);
        chk({28'h0, n}, 32'h8);
        rd(REG_FREE);
        chk(rv, {5'h0, MEM_BASE - 27'h3});
    endtask
    // Two entries at symbols 1 and 3; a 24-cycle window spans two list periods
    task automatic t_ctl;
        int na, nb, nh;
        na = 0;
        nb = 0;
        nh = 0;
        wr(REG_CADDR, 32'h0);
        wr(REG_CENTRY, 32'h3400_0001);
        wr(REG_CENTRY, 32'h0800_0003);
        wr(REG_CCOUNT, 32'h2);
        wr(REG_CTRL, 32'h14);
        rd(REG_STATUS);
        chk({8'h0, rv[31:8]}, 32'h3);
        repeat (16) @(posedge core_clk);
        repeat (24) begin
            @(posedge core_clk);
            #1;
            na += (rp == 6'h34 && lvl == LVL_ATT && mod_valid);
            nb += (rp == 6'h08 && lvl == LVL_MAX && cw && !mod_valid);
            nh += fstep;
        end
        chk(na, 32'h10);
        chk(nb, 32'h8);
        chk(nh, 32'h2);
    endtask
    // External trigger with a two-symbol start delay in retrigger mode
    task automatic t_dly;
        wr(REG_DELAY, 32'h2);
        wr(REG_CTRL, 32'h40);
        @(posedge core_clk);
        ext_trig <= 1'b1;
        @(posedge core_clk);
        ext_trig <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk({30'h0, echo, mod_valid}, 32'h2);
        repeat (4) @(posedge core_clk);
        #1 chk({31'h0, mod_valid}, 32'h0);
        repeat (5) @(posedge core_clk);
        #1 chk({31'h0, mod_valid}, 32'h1);
    endtask
    task automatic t_ext(input logic e);
        logic seen;
        seen = 1'b0;
        @(posedge core_clk);
        ext_trig <= 1'b1;
        repeat (12) begin
            @(posedge core_clk);
            ext_trig <= 1'b0;
            #1 seen |= echo;
        end
        chk({31'h0, seen}, {31'h0, e});
    endtask
    task automatic summarize;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        req = '0;
        ext_trig = 1'b0;
        env_in = 3'h0;
        tk = 2'h0;
        bit_tick = 1'b0;
        sym_tick = 1'b0;
        cyc = 0;
        bad_count = 0;
        total_checks = 0;
        repeat (4) @(posedge core_clk);
        chk({30'h0, lvl}, 32'h2);
        rst <= 1'b0;
        row(32'h104, 32'h1d4d, 32'h0f, 1'b1);
        row(32'h104, 32'h1d4c, 32'h0f, 1'b0);
        row(32'h214, 32'h09c4, 32'h47, 1'b1);
        row(32'h214, 32'h09c4, 32'h46, 1'b0);
        row(32'h214, 32'h09c5, 32'h46, 1'b1);
        row(32'h00c, 32'h0100, 32'h46, 1'b1);
        row(32'h005, 32'h0100, 32'h46, 1'b1);
        row(32'h001, 32'h0100, 32'h46, 1'b0);
        t_env;
        t_play;
        wr(REG_INHIB, 32'h8);
        t_ext(1'b1);
        t_ext(1'b0);
        t_ctl;
        t_dly;
        summarize;
    end
endmodule
